/* File: flwp_core.sv */
`timescale 1ns/100ps
// Functional notes
// - set-latch command sets write latch
// - latch cleared by reset, clear command, completion
// - latch clear rejects every write command except the block lock and address mode commands
// - busy flag high throughout any operation except while suspended
// - code zero protects nothing; top-down doubling
// - top bit one protects bottom-up; high codes all
// - protected targets refuse program and wipes
// - full wipe only when nothing protected
// - protect bits writable only outside hardware protection
// - guard pin low in lock select 01 freezes protect and lock0
// - lock select 00 needs only write latch
// - lock select 01 follows guard pin
// - lock select 10 locks until power cycle
// - lock select 11 also locks status until power cycle
// - deep sleep ignores all but wake, reset and status reads
// - per-block lock set, clear, query commands
// - global lock and global unlock commands
// - reset clears every per-block lock
// - first and last blocks lock per sector
// - scheme bit selects range or per-block locks
// - address width flag reports 4-byte mode
// - suspend sets paused flags; resume clears
// - secure lock sets once, then read-only
// - failed program sets program fail flag
// - protected program sets flag; resuming a suspended program clears
// - erase fail flag, same set and clear
module flwp_core
  import flwp_pkg::*;
#(
  parameter int unsigned REG_CYC = REG_WR_CYC
) (
  input  wire logic                    mclk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    sclk_i,
  input  wire logic                    cs_n_i,
  input  wire logic                    si_i,
  output      logic                    so_o,
  output      logic                    so_oe_o,
  input  wire logic                    wp_n_i,
  output      logic                    op_go_o,
  output      flwp_pkg::flwp_kind_t    op_kind_o,
  output      logic [flwp_pkg::ADDR_W-1:0] op_addr_o,
  output      logic [7:0]              op_data_o,
  input  wire logic                    op_done_i,
  input  wire logic                    op_fail_i,
  output      logic                    op_hold_o,
  output      logic                    busy_o
);
  import flwp_pkg::*;

  flwp_lnk_t         lq, ld, lbase;
  logic              lopen;
  flwp_out_t         oq;
  flwp_core_t        q, d;
  logic [7:0]        c, rd, dt, sr1, sr2, rbyte;
  logic [2:0]        nb, alen;
  logic [ADDR_W-1:0] a;
  logic              fe, paused, busy, acc, sr_ok, hit_s, hit_b, anyp, rd_cmd;

  function automatic logic is_erase(input flwp_kind_t k);
    return (k == K_SERASE) | (k == K_BERASE) | (k == K_CERASE) | (k == K_SECE);
  endfunction

  function automatic logic bp_hit(input logic [4:0] bp, input logic [11:0] b);
    logic [12:0] span;
    span = 13'h1 << (bp[3:0] - 4'h1);
    if (bp[3:0] == 4'h0) return 1'b0;
    if (bp[3:0] >= BP_ALL) return 1'b1;
    if (bp[4]) return {1'b0, b} < span;
    return {1'b0, b} >= (BP_NBLK - span);
  endfunction

  function automatic logic prot(input flwp_core_t s, input logic [ADDR_W-1:0] ad,
                                input logic whole);
    logic [11:0] b;
    logic [3:0]  n;
    b = ad[27:16];
    n = ad[15:12];
    if (!s.pbs) return bp_hit(s.bp, b);
    if (b == 12'h000) return whole ? |s.slo : s.slo[n];
    if (&b) return whole ? |s.shi : s.shi[n];
    return s.blk[b];
  endfunction

  // link side: shift in command and up to five argument bytes, mode 0
  assign lbase = lopen ? lq : '0;

  always_comb begin
    ld       = lbase;
    ld.sh    = {lbase.sh[6:0], si_i};
    ld.bit_n = lbase.bit_n + 3'd1;
    if (lbase.bit_n == 3'd7) begin
      if (lbase.nb != 3'd7) ld.nb = lbase.nb + 3'd1;
      case (lbase.nb)
        3'd0: ld.cmd = ld.sh;
        3'd1: ld.arg[39:32] = ld.sh;
        3'd2: ld.arg[31:24] = ld.sh;
        3'd3: ld.arg[23:16] = ld.sh;
        3'd4: ld.arg[15:8] = ld.sh;
        3'd5: ld.arg[7:0] = ld.sh;
        default: ;
      endcase
    end
  end

  // frame stays put after select rises so the core can decode it;
  // the first edge of a new frame restarts from zero
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) lopen <= 1'b0;
    else lopen <= 1'b1;
  end

  always_ff @(posedge sclk_i) begin
    lq <= ld;
  end

  // snap only moves while the frame is closed, so it is still during a read
  assign rd_cmd = (lq.nb != 3'd0) &
                  ((lq.cmd == CMD_SR1_RD) | (lq.cmd == CMD_SR2_RD) | (lq.cmd == CMD_LOCK_RD));
  assign rbyte  = (lq.cmd == CMD_SR1_RD) ? q.snap[23:16] :
                  (lq.cmd == CMD_SR2_RD) ? q.snap[15:8] : q.snap[7:0];

  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) oq <= '0;
    else begin
      oq.oe <= rd_cmd;
      oq.so <= rbyte[~lq.bit_n];
    end
  end

  // core side
  assign c      = lq.cmd;
  assign nb     = lq.nb;
  assign rd     = lq.arg[39:32];
  assign a      = q.addr_width_flag ? lq.arg[35:8] : {q.ear, lq.arg[39:16]};
  assign dt     = q.addr_width_flag ? lq.arg[7:0] : lq.arg[15:8];
  assign alen   = q.addr_width_flag ? 3'd5 : 3'd4;
  // select is kept active high so the reset value is the idle level
  assign fe     = ~q.cs_s[1] & q.cs_p;
  assign paused = q.esus | q.psus;
  assign busy   = q.act & ~paused;
  assign acc    = fe & (nb != 3'd0) & ~q.dpd & ~busy;
  // lock select 00, or 01 with guard pin high; 10 and 11 always refuse
  assign sr_ok  = q.write_latch_flag & ~q.lock_select_bit1 & (~q.lock_select_bit0 | q.wp_s[1]);
  assign hit_s  = prot(q, a, 1'b0);
  assign hit_b  = prot(q, a, 1'b1);
  assign anyp   = q.pbs ? (|q.blk | |q.slo | |q.shi) : (q.bp[3:0] != 4'h0);

  always_comb begin
    sr1              = 8'h00;
    sr1[SR1_LOCK_SELECT_BIT0]    = q.lock_select_bit0;
    sr1[SR1_BP +: 5] = q.bp;
    sr1[SR1_WL]      = q.write_latch_flag;
    sr1[SR1_BUSY]    = busy;
    sr2              = 8'h00;
    sr2[SR2_ESUS]    = q.esus;
    sr2[SR2_LOCK_SELECT_BIT1]    = q.lock_select_bit1;
    sr2[SR2_EF]      = q.ef;
    sr2[SR2_PF]      = q.pf;
    sr2[SR2_LB]      = q.lb;
    sr2[SR2_PSUS]    = q.psus;
    sr2[SR2_ADS]     = q.addr_width_flag;
  end

  always_comb begin
    logic       iss;
    flwp_kind_t ik;
    iss    = 1'b0;
    ik     = K_REG;
    d      = q;
    d.go   = 1'b0;
    d.cs_s = {q.cs_s[0], ~cs_n_i};
    d.cs_p = q.cs_s[1];
    d.wp_s = {q.wp_s[0], wp_n_i};
    if (busy) begin
      if (q.kind == K_REG) begin
        if (q.rcnt == 8'd0) begin
          d.act = 1'b0;
          d.write_latch_flag = 1'b0;
        end else d.rcnt = q.rcnt - 8'd1;
      end else if (op_done_i) begin
        d.act = 1'b0;
        d.write_latch_flag = 1'b0;
        if (op_fail_i) begin
          if (is_erase(q.kind)) d.ef = 1'b1;
          else d.pf = 1'b1;
        end
      end
    end
    if (fe & (nb != 3'd0)) begin
      d.arm = (c == CMD_RST_EN);
      if ((c == CMD_RST) & q.arm) begin
        d.write_latch_flag  = 1'b0;
        d.esus = 1'b0;
        d.psus = 1'b0;
        d.act  = 1'b0;
        d.dpd  = 1'b0;
        d.blk  = '0;
        d.slo  = '0;
        d.shi  = '0;
        d.addr_width_flag  = 1'b0;
        d.ear  = 4'h0;
        d.pbs  = 1'b0;
      end else if (q.dpd) begin
        if (c == CMD_WAKE) d.dpd = 1'b0;
      end else if (busy) begin
        // register writes cannot pause; an op ending now is not paused
        if ((c == CMD_PAUSE) & (q.kind != K_REG) & ~op_done_i) begin
          if (is_erase(q.kind)) d.esus = 1'b1;
          else d.psus = 1'b1;
        end
      end else begin
        case (c)
          CMD_SET_WL: d.write_latch_flag = 1'b1;
          CMD_CLR_WL: d.write_latch_flag = 1'b0;
          CMD_SR1_WR: if (sr_ok & (nb >= 3'd2)) begin
            d.lock_select_bit0 = rd[SR1_LOCK_SELECT_BIT0];
            d.bp   = rd[SR1_BP +: 5];
            iss    = 1'b1;
          end
          CMD_SR2_WR: if (sr_ok & (nb >= 3'd2)) begin
            d.lock_select_bit1 = rd[SR2_LOCK_SELECT_BIT1];
            d.lb   = q.lb | rd[SR2_LB];
            iss    = 1'b1;
          end
          CMD_EXT_WR: if (q.write_latch_flag & (nb >= 3'd2)) begin
            d.ear = rd[3:0];
            iss   = 1'b1;
          end
          CMD_NVCFG_WR, CMD_VCFG_WR: if (q.write_latch_flag & (nb > alen)) begin
            if (a[7:0] == CFG_PROT_ADDR) d.pbs = ~dt[CFG_PROT_BIT];
            else if (a[7:0] == CFG_ADDR_ADDR) d.addr_width_flag = (dt == CFG_ADDR4_VAL);
            iss = 1'b1;
          end
          CMD_ADDR4: d.addr_width_flag = 1'b1;
          CMD_ADDR3: d.addr_width_flag = 1'b0;
          CMD_PAGE_WR: if (q.write_latch_flag & (nb > alen)) begin
            if (hit_s) d.pf = 1'b1;
            else begin
              iss = 1'b1;
              ik  = K_PROG;
            end
          end
          CMD_SEC_WIPE: if (q.write_latch_flag & (nb >= alen)) begin
            if (hit_s) d.ef = 1'b1;
            else begin
              iss = 1'b1;
              ik  = K_SERASE;
            end
          end
          CMD_BLK_WIPE: if (q.write_latch_flag & (nb >= alen)) begin
            if (hit_b) d.ef = 1'b1;
            else begin
              iss = 1'b1;
              ik  = K_BERASE;
            end
          end
          CMD_CHIP_WIPE: if (q.write_latch_flag) begin
            if (anyp) d.ef = 1'b1;
            else begin
              iss = 1'b1;
              ik  = K_CERASE;
            end
          end
          CMD_SECR_PROG: if (q.write_latch_flag & (nb > alen)) begin
            if (q.lb) d.pf = 1'b1;
            else begin
              iss = 1'b1;
              ik  = K_SECP;
            end
          end
          CMD_SECR_ERASE: if (q.write_latch_flag & (nb >= alen)) begin
            if (q.lb) d.ef = 1'b1;
            else begin
              iss = 1'b1;
              ik  = K_SECE;
            end
          end
          CMD_SLEEP: d.dpd = 1'b1;
          CMD_RESUME: begin
            d.esus = 1'b0;
            d.psus = 1'b0;
            if (q.esus) d.ef = 1'b0;
            if (q.psus) d.pf = 1'b0;
          end
          CMD_LOCK, CMD_UNLOCK: if (q.pbs & (nb >= alen)) begin
            if (a[27:16] == 12'h000) d.slo[a[15:12]] = (c == CMD_LOCK);
            else if (&a[27:16]) d.shi[a[15:12]] = (c == CMD_LOCK);
            else d.blk[a[27:16]] = (c == CMD_LOCK);
          end
          CMD_LOCK_RD: if (q.pbs & (nb >= alen)) d.lkrd = hit_s;
          CMD_GLOCK: if (q.pbs) begin
            d.blk = '1;
            d.slo = '1;
            d.shi = '1;
          end
          CMD_GUNLOCK: if (q.pbs) begin
            d.blk = '0;
            d.slo = '0;
            d.shi = '0;
          end
          default: ;
        endcase
      end
    end
    if (iss) begin
      d.act   = 1'b1;
      d.kind  = ik;
      d.go    = 1'b1;
      d.oaddr = a;
      d.odata = dt;
      d.rcnt  = 8'(REG_CYC - 1);
    end
    if (~q.cs_s[1]) d.snap = {sr1, sr2, 7'h00, q.lkrd};
  end

  // power-on state: lock select 00, no locks, range scheme, 3-byte mode
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) q <= '0;
    else q <= d;
  end

  assign op_go_o   = q.go & (q.kind != K_REG);
  assign op_kind_o = q.kind;
  assign op_addr_o = q.oaddr;
  assign op_data_o = q.odata;
  assign op_hold_o = paused;
  assign busy_o    = busy;
  assign so_o      = oq.so;
  assign so_oe_o   = oq.oe;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  property p_wel_set;
    acc & (c == CMD_SET_WL) |=> q.write_latch_flag ##1 sr1[SR1_WL];
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set");

  property p_wel_done;
    busy & (q.kind != K_REG) & op_done_i |=> !q.write_latch_flag && !busy_o;
  endproperty
  a_wel_done: assert property (p_wel_done) else $error("latch kept");

  property p_no_wel;
    acc & !q.write_latch_flag & (c != CMD_SET_WL) |=> !q.act && $stable({q.bp, q.lock_select_bit0, q.lock_select_bit1, q.ear});
  endproperty
  a_no_wel: assert property (p_no_wel) else $error("write without latch");

  property p_busy;
    $rose(q.act) & (q.kind == K_REG) |-> busy_o [*2];
  endproperty
  a_busy: assert property (p_busy) else $error("busy dropped early");

  property p_range;
    op_go_o & !q.pbs & (op_kind_o != K_CERASE) |-> !bp_hit(q.bp, op_addr_o[27:16]);
  endproperty
  a_range: assert property (p_range) else $error("protected op issued");

  property p_chip;
    op_go_o & (op_kind_o == K_CERASE) |-> !anyp;
  endproperty
  a_chip: assert property (p_chip) else $error("chip wipe while protected");

  property p_guard;
    q.lock_select_bit0 & !q.lock_select_bit1 & !q.wp_s[1] |=> $stable({q.lock_select_bit0, q.bp});
  endproperty
  a_guard: assert property (p_guard) else $error("guard pin ignored");

  property p_srlock;
    q.lock_select_bit1 |=> $stable({q.lock_select_bit0, q.lock_select_bit1, q.bp, q.lb});
  endproperty
  a_srlock: assert property (p_srlock) else $error("locked status changed");

  property p_sleep;
    fe & q.dpd & (c == CMD_SET_WL) |=> $stable(q.write_latch_flag) && q.dpd;
  endproperty
  a_sleep: assert property (p_sleep) else $error("command in deep sleep");

  property p_gunlock;
    acc & q.pbs & (c == CMD_GUNLOCK) |=> !anyp;
  endproperty
  a_gunlock: assert property (p_gunlock) else $error("locks remain");

  property p_resume;
    acc & (c == CMD_RESUME) |=> !q.esus && !q.psus && !op_hold_o;
  endproperty
  a_resume: assert property (p_resume) else $error("paused after resume");

  c_prog: cover property (op_go_o & (op_kind_o == K_PROG));
  c_pause: cover property ($rose(op_hold_o));
  c_refuse: cover property (acc & q.write_latch_flag & hit_s & (c == CMD_PAGE_WR));
  c_lock: cover property (acc & q.pbs & (c == CMD_GLOCK));

endmodule

/* File: flwp_pkg.sv */
package flwp_pkg;

  localparam int          ADDR_W   = 28;
  localparam int          NBLK     = 4096;
  localparam logic [12:0] BP_NBLK  = 13'h1000;
  localparam logic [3:0]  BP_ALL   = 4'hd;
  localparam int          REG_WR_CYC = 16;

  localparam logic [7:0] CMD_SET_WL     = 8'h06;
  localparam logic [7:0] CMD_CLR_WL     = 8'h04;
  localparam logic [7:0] CMD_SR1_WR     = 8'h01;
  localparam logic [7:0] CMD_SR2_WR     = 8'h31;
  localparam logic [7:0] CMD_SR1_RD     = 8'h05;
  localparam logic [7:0] CMD_SR2_RD     = 8'h35;
  localparam logic [7:0] CMD_EXT_WR     = 8'hc5;
  localparam logic [7:0] CMD_NVCFG_WR   = 8'hb1;
  localparam logic [7:0] CMD_VCFG_WR    = 8'h81;
  localparam logic [7:0] CMD_PAGE_WR    = 8'h02;
  localparam logic [7:0] CMD_SEC_WIPE   = 8'h20;
  localparam logic [7:0] CMD_BLK_WIPE   = 8'hd8;
  localparam logic [7:0] CMD_CHIP_WIPE  = 8'hc7;
  localparam logic [7:0] CMD_SECR_PROG  = 8'h42;
  localparam logic [7:0] CMD_SECR_ERASE = 8'h44;
  localparam logic [7:0] CMD_ADDR4      = 8'hb7;
  localparam logic [7:0] CMD_ADDR3      = 8'he9;
  localparam logic [7:0] CMD_SLEEP      = 8'hb9;
  localparam logic [7:0] CMD_WAKE       = 8'hab;
  localparam logic [7:0] CMD_PAUSE      = 8'h75;
  localparam logic [7:0] CMD_RESUME     = 8'h7a;
  localparam logic [7:0] CMD_RST_EN     = 8'h66;
  localparam logic [7:0] CMD_RST        = 8'h99;
  localparam logic [7:0] CMD_LOCK       = 8'h36;
  localparam logic [7:0] CMD_UNLOCK     = 8'h39;
  localparam logic [7:0] CMD_LOCK_RD    = 8'h3d;
  localparam logic [7:0] CMD_GLOCK      = 8'h7e;
  localparam logic [7:0] CMD_GUNLOCK    = 8'h98;

  localparam int SR1_BUSY = 0;
  localparam int SR1_WL   = 1;
  localparam int SR1_BP   = 2;
  localparam int SR1_LOCK_SELECT_BIT0 = 7;
  localparam int SR2_ADS  = 0;
  localparam int SR2_PSUS = 2;
  localparam int SR2_LB   = 3;
  localparam int SR2_PF   = 4;
  localparam int SR2_EF   = 5;
  localparam int SR2_LOCK_SELECT_BIT1 = 6;
  localparam int SR2_ESUS = 7;

  localparam logic [7:0] CFG_PROT_ADDR = 8'h04;
  localparam int         CFG_PROT_BIT  = 2;
  localparam logic [7:0] CFG_ADDR_ADDR = 8'h05;
  localparam logic [7:0] CFG_ADDR4_VAL = 8'hfe;

  typedef enum logic [2:0] {K_REG, K_PROG, K_SECP, K_SERASE, K_BERASE, K_CERASE, K_SECE}
    flwp_kind_t;

  typedef struct packed {
    logic [2:0]  bit_n;
    logic [2:0]  nb;
    logic [7:0]  sh;
    logic [7:0]  cmd;
    logic [39:0] arg;
  } flwp_lnk_t;

  typedef struct packed {
    logic so;
    logic oe;
  } flwp_out_t;

  typedef struct packed {
    logic [1:0]        cs_s;
    logic              cs_p;
    logic [1:0]        wp_s;
    logic              write_latch_flag;
    logic              lock_select_bit0;
    logic              lock_select_bit1;
    logic [4:0]        bp;
    logic              lb;
    logic              ef;
    logic              pf;
    logic              esus;
    logic              psus;
    logic              addr_width_flag;
    logic [3:0]        ear;
    logic              pbs;
    logic              dpd;
    logic              arm;
    logic              act;
    flwp_kind_t        kind;
    logic [7:0]        rcnt;
    logic              go;
    logic [ADDR_W-1:0] oaddr;
    logic [7:0]        odata;
    logic              lkrd;
    logic [NBLK-1:0]   blk;
    logic [15:0]       slo;
    logic [15:0]       shi;
    logic [23:0]       snap;
  } flwp_core_t;

endpackage

/* File: flwp_host.sv */
`timescale 1ns/100ps
module flwp_host (
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic       si_o,
  input  wire logic  so_i,
  input  wire logic  so_oe_i,
  output logic [7:0] rd_o,
  output logic       rd_tgl_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    rd_o = 8'h00;
    rd_tgl_o = 1'b0;
  end

  // mode 0, msb first; the clock is parked low between frames
  task automatic xfer(input logic [47:0] b, input int n, input int nrd);
    logic [7:0] r;
    r = 8'h00;
    cs_n_o = 1'b0;
    for (int i = 0; i < 8 * (n + nrd); i++) begin
      si_o = (i < 8 * n) ? b[47 - i] : ~si_o;
      #15 sclk_o = 1'b1;
      r = {r[6:0], so_oe_i ? so_i : 1'bx};
      #15 sclk_o = 1'b0;
    end
    #15 cs_n_o = 1'b1;
    // flip the idle data line so a stale level is never taken for data
    si_o = ~si_o;
    rd_o = r;
    if (nrd > 0) begin
      rd_tgl_o = ~rd_tgl_o;
    end
  endtask
endmodule

/* File: flwp_core_tb.sv */
`timescale 1ns/100ps
module flwp_core_tb;
  import flwp_pkg::*;
  localparam int unsigned REG_CYC = 2;
  localparam int          ENG_DLY = 300;
  typedef struct {logic [7:0] v; logic [7:0] m;} flwp_rexp_t;
  typedef struct {flwp_kind_t k; logic [27:0] a; logic [7:0] d; logic ca;} flwp_oexp_t;
  typedef struct {logic [7:0] c; logic [4:0] bp; logic [27:0] a; logic pr;} flwp_row_t;
  logic              mclk_i, nrst_i, sclk, cs_n, si, so, so_oe, wp_n, rd_tgl;
  logic              op_go, op_done, op_fail, op_hold, busy, fail_next;
  flwp_kind_t        op_kind;
  logic [ADDR_W-1:0] op_addr;
  logic [7:0]        op_data, rd;
  int                num_errors, checks_done, eng_cnt;
  flwp_rexp_t        rq[$];
  flwp_oexp_t        oq[$];
  flwp_row_t         tbl[12];

  flwp_core #(.REG_CYC(REG_CYC)) DUT (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .so_o(so),
    .so_oe_o(so_oe), .wp_n_i(wp_n), .op_go_o(op_go), .op_kind_o(op_kind),
    .op_addr_o(op_addr), .op_data_o(op_data), .op_done_i(op_done), .op_fail_i(op_fail),
    .op_hold_o(op_hold), .busy_o(busy)
  );
  flwp_host u_host (
    .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe), .rd_o(rd),
    .rd_tgl_o(rd_tgl)
  );

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    if (rq.size() + oq.size() != 0) begin
      num_errors++;
      $display("FAIL pending results expected 0 seen %0d", rq.size() + oq.size());
    end
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // array engine stand-in: counts only while not suspended
  always @(negedge mclk_i) begin
    op_done <= 1'b0;
    op_fail <= 1'b0;
    if (op_go === 1'b1) begin
      eng_cnt <= ENG_DLY;
    end else if (eng_cnt > 0 && op_hold === 1'b0) begin
      eng_cnt <= eng_cnt - 1;
      if (eng_cnt == 1) begin
        op_done <= 1'b1;
        op_fail <= fail_next;
      end
    end
  end

  initial begin
    flwp_rexp_t e;
    #1;
    forever begin
      @(rd_tgl);
      #1;
      if (rq.size() == 0) begin
        num_errors++;
        $display("FAIL status expected none seen %h", rd);
      end else begin
        e = rq.pop_front();
        check("status", 32'(e.v & e.m), 32'(rd & e.m));
      end
    end
  end

  always @(posedge mclk_i) begin
    flwp_oexp_t o;
    if (nrst_i === 1'b1 && op_go === 1'b1) begin
      if (oq.size() == 0) begin
        num_errors++;
        $display("FAIL op start expected none seen %h", op_addr);
      end else begin
        o = oq.pop_front();
        check("op kind", 32'(o.k), 32'(op_kind));
        if (o.ca) check("op addr", 32'(o.a), 32'(op_addr));
        if (o.k == K_PROG) check("op data", 32'(o.d), 32'(op_data));
      end
    end
  end

  task automatic fr(input logic [47:0] b, input int n, input int nrd = 0);
    u_host.xfer(b, n, nrd);
    #80;
  endtask

  task automatic c1(input logic [7:0] c);
    fr({c, 40'h0}, 1);
  endtask

  task automatic idle();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 2000) begin
      @(negedge mclk_i);
      i++;
    end
    if (i == 2000) begin
      num_errors++;
      $display("FAIL busy expected 0 seen %b", busy);
      finish_test();
    end
  endtask

  task automatic rs(input logic sel, input logic [7:0] v, input logic [7:0] m = 8'hff);
    rq.push_back('{v, m});
    fr({sel ? CMD_SR2_RD : CMD_SR1_RD, 40'h0}, 1, 1);
  endtask

  task automatic wop(input logic [47:0] b, input int n, input logic ex, input flwp_kind_t k,
                     input logic [27:0] a, input logic ca = 1'b1);
    c1(CMD_SET_WL);
    if (ex) oq.push_back('{k, a, b[8 * (6 - n) +: 8], ca});
    fr(b, n);
  endtask

  task automatic wsr(input logic [7:0] c, input logic [7:0] d);
    wop({c, d, 32'h0}, 2, 1'b0, K_REG, 28'h0);
    idle();
  endtask

  task automatic rst();
    @(negedge mclk_i);
    nrst_i = 1'b0;
    repeat (8) @(negedge mclk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge mclk_i);
  endtask

  task automatic set_wp(input logic v);
    @(negedge mclk_i);
    wp_n = v;
    repeat (4) @(negedge mclk_i);
  endtask

  function automatic flwp_kind_t kd(input logic [7:0] c);
    return c == CMD_PAGE_WR ? K_PROG : c == CMD_SEC_WIPE ? K_SERASE : K_BERASE;
  endfunction

  initial begin
    logic [27:0] ra;
    logic [7:0]  dat;
    nrst_i = 1'b0;
    wp_n = 1'b1;
    op_done = 1'b0;
    op_fail = 1'b0;
    fail_next = 1'b0;
    eng_cnt = 0;
    num_errors = 0;
    checks_done = 0;
    tbl = '{'{CMD_PAGE_WR, 5'h01, 28'h0fff0000, 1}, '{CMD_PAGE_WR, 5'h01, 28'h0ffeffff, 0},
            '{CMD_PAGE_WR, 5'h11, 28'h0000ffff, 1}, '{CMD_PAGE_WR, 5'h11, 28'h00010000, 0},
            '{CMD_PAGE_WR, 5'h0c, 28'h08000000, 1}, '{CMD_PAGE_WR, 5'h0c, 28'h07ffffff, 0},
            '{CMD_PAGE_WR, 5'h1c, 28'h07ffffff, 1}, '{CMD_BLK_WIPE, 5'h0d, 28'h00000000, 1},
            '{CMD_SEC_WIPE, 5'h1e, 28'h0fff0000, 1}, '{CMD_BLK_WIPE, 5'h03, 28'h0ffb0000, 0},
            '{CMD_SEC_WIPE, 5'h03, 28'h0ffc0000, 1}, '{CMD_PAGE_WR, 5'h10, 28'h0fff0000, 0}};
    ra = 28'($urandom(32'h1689d87a));
    rst();
    rs(0, 8'h00);
    rs(1, 8'h00);
    fr({CMD_SR1_WR, 8'h04, 32'h0}, 2);
    idle();
    fr({CMD_PAGE_WR, 24'h001000, 8'h55, 8'h0}, 5);
    rs(0, 8'h00);
    c1(CMD_SET_WL);
    rs(0, 8'h02);
    c1(CMD_CLR_WL);
    rs(0, 8'h00);
    wsr(CMD_SR1_WR, 8'h04);
    rs(0, 8'h04);
    wsr(CMD_SR2_WR, 8'h03);
    rs(1, 8'h00);
    $display("test latch done");
    wsr(CMD_EXT_WR, 8'h0f);
    rs(0, 8'h04);
    wop({CMD_PAGE_WR, 24'hff0000, 8'h11, 8'h0}, 5, 1'b0, K_REG, 28'h0);
    rs(1, 8'h10);
    wop({CMD_PAGE_WR, 24'hfe0010, 8'h22, 8'h0}, 5, 1'b1, K_PROG, 28'hffe0010);
    rs(0, 8'h07);
    c1(CMD_PAUSE);
    rs(1, 8'h14);
    c1(CMD_RESUME);
    rs(1, 8'h00);
    idle();
    rs(0, 8'h04);
    fail_next = 1'b1;
    wop({CMD_PAGE_WR, 24'hfe0020, 8'h33, 8'h0}, 5, 1'b1, K_PROG, 28'hffe0020);
    idle();
    fail_next = 1'b0;
    rs(1, 8'h10);
    wop({CMD_SEC_WIPE, 24'hfe1000, 16'h0}, 4, 1'b1, K_SERASE, 28'hffe1000);
    c1(CMD_PAUSE);
    rs(1, 8'h90);
    c1(CMD_RST_EN);
    c1(CMD_RST);
    rs(1, 8'h00, 8'h84);
    rs(0, 8'h04);
    $display("test suspend done");
    rst();
    c1(CMD_ADDR4);
    rs(1, 8'h01);
    foreach (tbl[i]) begin
      wsr(CMD_SR1_WR, {1'b0, tbl[i].bp, 2'b00});
      dat = 8'($urandom());
      wop({tbl[i].c, 4'h0, tbl[i].a, dat}, 6, !tbl[i].pr, kd(tbl[i].c), tbl[i].a);
      idle();
    end
    rs(1, 8'h20, 8'h20);
    dat = 8'($urandom());
    wop({CMD_PAGE_WR, 4'h0, ra, dat}, 6, 1'b1, K_PROG, ra);
    idle();
    wop({CMD_CHIP_WIPE, 40'h0}, 1, 1'b1, K_CERASE, 28'h0, 1'b0);
    idle();
    wsr(CMD_SR1_WR, 8'h04);
    wop({CMD_CHIP_WIPE, 40'h0}, 1, 1'b0, K_REG, 28'h0);
    idle();
    $display("test range done");
    rst();
    wsr(CMD_SR1_WR, 8'h80);
    rs(0, 8'h80);
    set_wp(1'b0);
    wsr(CMD_SR1_WR, 8'h04);
    c1(CMD_CLR_WL);
    rs(0, 8'h80);
    set_wp(1'b1);
    wsr(CMD_SR1_WR, 8'h88);
    rs(0, 8'h88);
    wsr(CMD_SR2_WR, 8'h40);
    rs(1, 8'h40);
    wsr(CMD_SR1_WR, 8'h00);
    c1(CMD_CLR_WL);
    rs(0, 8'h88);
    rst();
    wsr(CMD_SR2_WR, 8'h40);
    wsr(CMD_SR1_WR, 8'h04);
    c1(CMD_CLR_WL);
    rs(0, 8'h00);
    rst();
    rs(1, 8'h00);
    c1(CMD_SLEEP);
    c1(CMD_SET_WL);
    c1(CMD_WAKE);
    rs(0, 8'h00);
    c1(CMD_SLEEP);
    c1(CMD_RST_EN);
    c1(CMD_RST);
    c1(CMD_SET_WL);
    rs(0, 8'h02);
    c1(CMD_CLR_WL);
    $display("test lock select done");
    wsr(CMD_SR1_WR, 8'h34);
    wop({CMD_VCFG_WR, 24'h000004, 8'hfb, 8'h0}, 5, 1'b0, K_REG, 28'h0);
    idle();
    fr({CMD_LOCK, 24'h010000, 16'h0}, 4);
    wop({CMD_PAGE_WR, 24'h010000, 8'h44, 8'h0}, 5, 1'b0, K_REG, 28'h0);
    idle();
    wop({CMD_PAGE_WR, 24'h020000, 8'h45, 8'h0}, 5, 1'b1, K_PROG, 28'h0020000);
    idle();
    fr({CMD_LOCK_RD, 24'h010000, 16'h0}, 4);
    rq.push_back('{8'h01, 8'hff});
    fr({CMD_LOCK_RD, 24'h010000, 16'h0}, 4, 1);
    fr({CMD_UNLOCK, 24'h010000, 16'h0}, 4);
    wop({CMD_PAGE_WR, 24'h010000, 8'h46, 8'h0}, 5, 1'b1, K_PROG, 28'h0010000);
    idle();
    c1(CMD_GLOCK);
    wop({CMD_SEC_WIPE, 24'h00f000, 16'h0}, 4, 1'b0, K_REG, 28'h0);
    idle();
    c1(CMD_GUNLOCK);
    fr({CMD_LOCK, 24'h001000, 16'h0}, 4);
    wop({CMD_SEC_WIPE, 24'h002000, 16'h0}, 4, 1'b1, K_SERASE, 28'h0002000);
    idle();
    wop({CMD_SEC_WIPE, 24'h001000, 16'h0}, 4, 1'b0, K_REG, 28'h0);
    idle();
    $display("test block locks done");
    finish_test();
  end
endmodule
